/* src/upc_defs.vh */
/*
 Constants for the USB PHY control register block: offsets, field positions,
 reset values, line states and interrupt status bits. Assumes inclusion by bare name.
*/
`ifndef UPC_DEFS_VH
`define UPC_DEFS_VH

// Register offsets (byte addresses)
`define UPC_OFF_PHY_CONTROL   8'h40
`define UPC_OFF_IRQ_STATUS    8'h44
`define UPC_OFF_IRQ_ENABLE    8'h48
`define UPC_OFF_IRQ_CLEAR     8'h4C
`define UPC_OFF_LINE_STATUS   8'h50

// Control field positions
`define UPC_BIT_PD_DISABLE    18
`define UPC_BIT_RESUME_SE0    13
`define UPC_BIT_RESUME_K      12
`define UPC_FILT_HI           11
`define UPC_FILT_LO           8
`define UPC_BIT_AUTO_RESUME   7
`define UPC_CONF_HI           6
`define UPC_CONF_LO           4

// Reset values
`define UPC_CTRL_RESET        32'h0000_0000

// Line states
`define UPC_LS_SE0            2'h0
`define UPC_LS_J              2'h1
`define UPC_LS_K              2'h2

// Interrupt status bits
`define UPC_IRQ_SE0           0
`define UPC_IRQ_K             1
`define UPC_IRQ_LS_CHANGE     2

`endif

/* src/upc_phy_control.v */
/*
 USB PHY control register with line-state filter and suspend resume control.
 Assumes a simple register port with one-cycle strobes, read data one cycle
 later, and line state / suspend inputs arriving asynchronously from the PHY.
 Also holds the sticky resume causes and a small interrupt unit with status,
 enable and clear registers.
 Assumes software never strobes read and write in the same cycle.
*/
// Implementation choice: the plain strobed port.
//
// Contract
// [R1] Control bit 18 set disables pulldowns on the two USB-related ports.
// [R2] Auto-resume from SE0 reset sets bit 13 until software writes 0.
// [R3] Auto-resume from K resume sets bit 12 until software writes 0.
// [R4] Line-state changes propagate after two to the power bits 11:8 clocks.
// [R5] Bit 7 set: hardware resumes from suspend; else software polls filtered state.
// [R6] Bits 6:4 drive the three PHY configuration input pins directly.
// [R7] Filter restarts its count whenever the raw line state changes early.
`timescale 1ns/1ns
`include "upc_defs.vh"

module upc_phy_control (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// PHY side
	input  wire [1:0]  line_state_raw,
	input  wire        suspended,
	output reg         pulldown_disable,
	output reg  [2:0]  phy_config_pins_field,
	output reg         resume_req,
	output reg  [1:0]  line_state_filt,
	// Interrupt
	output reg         irq
);

	// Synchroniser stages
	reg  [1:0]  ls_meta_q;
	reg  [1:0]  ls_sync_q;
	reg  [1:0]  susp_sync_q;
	// Line-state filter
	reg  [1:0]  ls_cand_q;
	reg  [15:0] filt_cnt_q;
	reg  [1:0]  prev_filt_q;
	// Control fields
	reg         pd_dis_q;
	reg         res_se0_q;
	reg         res_k_q;
	reg  [3:0]  filt_log_q;
	reg         auto_res_q;
	reg  [2:0]  conf_q;
	// Interrupt state
	reg  [2:0]  irq_stat_q;
	reg  [2:0]  irq_en_q;
	// Next values
	reg  [2:0]  clr_mask;
	reg         pd_dis_d;
	reg  [2:0]  conf_d;
	reg         res_se0_d;
	reg         res_k_d;
	reg         resume_d;
	reg  [2:0]  irq_en_d;
	reg  [2:0]  irq_stat_d;
	reg         irq_d;

	wire        ctrl_wr = reg_wr && (reg_addr == `UPC_OFF_PHY_CONTROL);
	wire        clr_wr  = reg_wr && (reg_addr == `UPC_OFF_IRQ_CLEAR);
	wire        en_wr   = reg_wr && (reg_addr == `UPC_OFF_IRQ_ENABLE);
	wire        susp    = susp_sync_q[1];

	// Filter terminal count: 2**n - 1 for a 2**n clock delay
	function [15:0] filt_limit;
		input [3:0] lg;
		begin
			filt_limit = (16'h0001 << lg) - 16'h0001;
		end
	endfunction

	wire [15:0] filt_lim = filt_limit(filt_log_q);

	// Auto-resume events: suspended, enabled, no request pending, filtered state is SE0 or K
	wire        se0_evt = susp && auto_res_q && !resume_req &&
	                      (line_state_filt == `UPC_LS_SE0);
	wire        k_evt   = susp && auto_res_q && !resume_req &&
	                      (line_state_filt == `UPC_LS_K);
	wire        ls_chg  = (prev_filt_q != line_state_filt);
	wire [2:0]  evts    = {ls_chg, k_evt, se0_evt};

	wire [31:0] ctrl_view = {13'h0000, pd_dis_q, 4'h0, res_se0_q, res_k_q,
	                         filt_log_q, auto_res_q, conf_q, 4'h0};

	// Next values of control fields, cause bits, resume request and interrupt
	always @* begin
		clr_mask   = clr_wr ? reg_wdata[2:0] : 3'h0;
		// [R1] Pulldown disable
		pd_dis_d   = ctrl_wr ? reg_wdata[`UPC_BIT_PD_DISABLE] : pd_dis_q;
		// [R6] Configuration pins
		conf_d     = ctrl_wr ? reg_wdata[`UPC_CONF_HI:`UPC_CONF_LO] : conf_q;
		// [R2] SE0 cause sticky, set wins over a clear
		res_se0_d  = res_se0_q;
		if (se0_evt)
			res_se0_d = 1'b1;
		else if (ctrl_wr && !reg_wdata[`UPC_BIT_RESUME_SE0])
			res_se0_d = 1'b0;
		// [R3] K cause sticky, set wins over a clear
		res_k_d    = res_k_q;
		if (k_evt)
			res_k_d = 1'b1;
		else if (ctrl_wr && !reg_wdata[`UPC_BIT_RESUME_K])
			res_k_d = 1'b0;
		// [R5] Hardware resume request held until suspend ends
		resume_d   = resume_req;
		if (se0_evt || k_evt)
			resume_d = 1'b1;
		else if (!susp)
			resume_d = 1'b0;
		// Status set wins over clear; irq follows next status and enable
		irq_en_d   = en_wr ? reg_wdata[2:0] : irq_en_q;
		irq_stat_d = (irq_stat_q & ~clr_mask) | evts;
		irq_d      = |(irq_stat_d & irq_en_d);
	end

	// Synchronisers for PHY inputs
	// Both inputs are asynchronous; only the second stage feeds logic
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ls_meta_q   <= 2'h1;
			ls_sync_q   <= 2'h1;
			susp_sync_q <= 2'h0;
		end else begin
			ls_meta_q   <= line_state_raw;
			ls_sync_q   <= ls_meta_q;
			susp_sync_q <= {susp_sync_q[0], suspended};
		end
	end

	// [R4] Power-of-two delay
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ls_cand_q       <= `UPC_LS_J;
			filt_cnt_q      <= 16'h0000;
			line_state_filt <= `UPC_LS_J;
			prev_filt_q     <= `UPC_LS_J;
		end else begin
			prev_filt_q <= line_state_filt;
			// [R7] Restart on change
			if (ls_sync_q != ls_cand_q) begin
				ls_cand_q  <= ls_sync_q;
				filt_cnt_q <= 16'h0000;
			end else if (ls_cand_q != line_state_filt) begin
				if (filt_cnt_q >= filt_lim) begin
					line_state_filt <= ls_cand_q;
					filt_cnt_q      <= 16'h0000;
				end else begin
					filt_cnt_q <= filt_cnt_q + 16'h0001;
				end
			end
		end
	end

	// Control register and outputs
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pd_dis_q              <= 1'b0;
			res_se0_q             <= 1'b0;
			res_k_q               <= 1'b0;
			filt_log_q            <= 4'h0;
			auto_res_q            <= 1'b0;
			conf_q                <= 3'h0;
			pulldown_disable      <= 1'b0;
			phy_config_pins_field <= 3'h0;
			resume_req            <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				filt_log_q <= reg_wdata[`UPC_FILT_HI:`UPC_FILT_LO];
				auto_res_q <= reg_wdata[`UPC_BIT_AUTO_RESUME];
			end
			pd_dis_q              <= pd_dis_d;
			conf_q                <= conf_d;
			res_se0_q             <= res_se0_d;
			res_k_q               <= res_k_d;
			resume_req            <= resume_d;
			pulldown_disable      <= pd_dis_d;
			phy_config_pins_field <= conf_d;
		end
	end

	// Interrupt status: set beats clear
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_stat_q <= 3'h0;
			irq_en_q   <= 3'h0;
			irq        <= 1'b0;
		end else begin
			irq_en_q   <= irq_en_d;
			irq_stat_q <= irq_stat_d;
			irq        <= irq_d;
		end
	end

	// Read port
	// Read data stand for the one cycle after the strobe, zero otherwise
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`UPC_OFF_PHY_CONTROL: reg_rdata <= ctrl_view;
				`UPC_OFF_IRQ_STATUS:  reg_rdata <= {29'h0000_0000, irq_stat_q};
				`UPC_OFF_IRQ_ENABLE:  reg_rdata <= {29'h0000_0000, irq_en_q};
				`UPC_OFF_LINE_STATUS: reg_rdata <= {29'h0000_0000, susp, line_state_filt};
				default:              reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

/* test/upc_phy_model.sv */
/* PHY line model: raw line state and suspend level.
 Assumes the bench calls drive() to move the lines. */
`timescale 1ns/1ns
module upc_phy_model (
	// PHY side
	input  wire        clk_sys,
	output logic [1:0] line_state_raw,
	output logic       suspended
);
	initial begin
		line_state_raw = 2'h1;
		suspended = 1'b0;
	end
	task automatic drive(input logic [1:0] ls, input logic sp);
		@(posedge clk_sys);
		line_state_raw <= ls;
		suspended <= sp;
	endtask
endmodule

/* test/upc_phy_control_checker.sv */
/* Checker of the control register outputs.
 Assumes binding to upc_phy_control. */
`timescale 1ns/1ns
module upc_phy_control_checker (
	// Watched ports
	input wire        clk_sys,
	input wire        rst,
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire [1:0]  line_state_raw,
	input wire        pulldown_disable,
	input wire [2:0]  phy_config_pins_field,
	input wire        resume_req,
	input wire [1:0]  line_state_filt
);
	wire ctl_wr = reg_wr && reg_addr == 8'h40;
	reg  ar_q;
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			ar_q <= 1'b0;
		else if (ctl_wr)
			ar_q <= reg_wdata[7];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_pd_write: assert property (ctl_wr |=> pulldown_disable == $past(reg_wdata[18]))
		else $error("pulldown wrong");
	chk_pd_hold: assert property (!ctl_wr |=> $stable(pulldown_disable))
		else $error("pulldown moved");
	chk_conf_write: assert property (ctl_wr |=> phy_config_pins_field == $past(reg_wdata[6:4]))
		else $error("conf wrong");
	chk_conf_hold: assert property (!ctl_wr |=> $stable(phy_config_pins_field))
		else $error("conf moved");
	chk_cause_state: assert property ($rose(resume_req) |-> line_state_filt != 2'h1)
		else $error("resume on J");
	chk_auto_enable: assert property ($rose(resume_req) |-> ar_q)
		else $error("resume disabled");
	chk_filt_src: assert property ($changed(line_state_filt) |-> line_state_filt ==
		$past(line_state_raw, 3) || line_state_filt == $past(line_state_raw, 4))
		else $error("filter value");
endmodule
bind upc_phy_control upc_phy_control_checker u_chk (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.line_state_raw(line_state_raw), .pulldown_disable(pulldown_disable),
	.phy_config_pins_field(phy_config_pins_field), .resume_req(resume_req),
	.line_state_filt(line_state_filt));

/* test/tb_usb_phy_control_register.sv */
/* Testbench of the control register block.
 Assumes the PHY model and bound checker. */
`timescale 1ns/1ns
module tb_usb_phy_control_register;
	logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0, d;
	wire  [31:0] reg_rdata;
	wire  [1:0]  line_state_raw, line_state_filt;
	wire  [2:0]  phy_config_pins_field;
	wire         suspended, pulldown_disable, resume_req, irq;
	int          n_mismatch = 0, cmp_count = 0, n;
	always #2 clk_sys = ~clk_sys;
	upc_phy_model phy (.clk_sys(clk_sys), .line_state_raw(line_state_raw),
		.suspended(suspended));
	upc_phy_control dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.line_state_raw(line_state_raw), .suspended(suspended), .irq(irq),
		.pulldown_disable(pulldown_disable), .phy_config_pins_field(phy_config_pins_field),
		.resume_req(resume_req), .line_state_filt(line_state_filt));
	task automatic stop_test();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic ok);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t value mismatch", $time);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic t_ctrl();
		wr(8'h40, 32'h0004_02D0);
		#1 chk(pulldown_disable === 1'b1 && phy_config_pins_field === 3'h5);
		rd(8'h40);
		chk(d[18:4] === 15'h402D);
		rd(8'h7C);
		chk(d === 32'h0000_0000);
	endtask
	task automatic t_filter();
		phy.drive(2'h2, 1'b0);
		phy.drive(2'h2, 1'b0);
		phy.drive(2'h1, 1'b0);
		repeat (10) @(posedge clk_sys);
		chk(line_state_filt === 2'h1);
		phy.drive(2'h2, 1'b0);
		for (n = 0; line_state_filt !== 2'h2; n++) begin
			if (n == 30) begin
				n_mismatch++;
				stop_test();
			end
			@(posedge clk_sys);
		end
		chk(n >= 6 && n <= 10);
	endtask
	task automatic t_resume();
		wr(8'h48, 32'h0000_0003);
		phy.drive(2'h2, 1'b1);
		repeat (12) @(posedge clk_sys);
		rd(8'h40);
		chk(d[13:12] === 2'b01 && resume_req === 1'b1 && irq === 1'b1);
		rd(8'h44);
		chk(d[2:0] === 3'b110);
		phy.drive(2'h1, 1'b0);
		repeat (12) @(posedge clk_sys);
		wr(8'h40, 32'h0000_0280);
		wr(8'h4C, 32'h0000_0007);
		rd(8'h40);
		chk(d[13:12] === 2'b00 && irq === 1'b0);
		phy.drive(2'h0, 1'b1);
		repeat (12) @(posedge clk_sys);
		rd(8'h40);
		chk(d[13:12] === 2'b10);
		phy.drive(2'h1, 1'b0);
		repeat (12) @(posedge clk_sys);
		wr(8'h40, 32'h0000_0200);
		phy.drive(2'h2, 1'b1);
		repeat (12) @(posedge clk_sys);
		rd(8'h40);
		chk(d[13:12] === 2'b00 && resume_req === 1'b0);
		rd(8'h50);
		chk(d[2:0] === 3'b110);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		t_ctrl();
		t_filter();
		t_resume();
		stop_test();
	end
endmodule
